// file: verilog/dmrc_params.svh
// Constants of the DRAM mode-word bank and its controller
`ifndef DMRC_PARAMS_SVH
`define DMRC_PARAMS_SVH
// ----------------------------------------
// Bus widths
// ----------------------------------------
`define DMRC_WORD_W 11
`define DMRC_ADDR_W 21
`define DMRC_SPLIT 6
`define DMRC_ADDR_IN_MUX 5'h0B
`define DMRC_ADDR_IN_FULL 5'h14
// ----------------------------------------
// Word zero fields
// ----------------------------------------
`define DMRC_RC_LSB 0
`define DMRC_LAT_LSB 4
`define DMRC_DLL_EN_BIT 8
`define DMRC_MUX_BIT 9
`define DMRC_RES0_MASK 11'h400
`define DMRC_WORD0_RST 11'h000
`define DMRC_LAT_BASE 5'h05
`define DMRC_RC_MIN 4'h3
`define DMRC_RC_MAX 4'h9
// ----------------------------------------
// Word one fields
// ----------------------------------------
`define DMRC_DRV_LSB 0
`define DMRC_DRV_60 2'h1
`define DMRC_ODT_LSB 2
`define DMRC_ODT_OFF 3'h0
`define DMRC_DLLRST_BIT 5
`define DMRC_CAL_SHORT_BIT 6
`define DMRC_CAL_GO_BIT 7
`define DMRC_REF_MULTI_BIT 8
`define DMRC_BL_LSB 9
`define DMRC_BL_2 2'h0
`define DMRC_BL_4 2'h1
`define DMRC_BL_8 2'h2
`define DMRC_WORD1_RST 11'h000
// ----------------------------------------
// Word select on the bank address
// ----------------------------------------
`define DMRC_SEL_WORD0 2'h0
`define DMRC_SEL_WORD1 2'h1
// ----------------------------------------
// Timing counts in clock cycles
// ----------------------------------------
`define DMRC_DLL_LOCK_CYC 512
`define DMRC_MRSC_CYC 12
`define DMRC_CAL_INIT_CYC 512
`define DMRC_CAL_OPER_CYC 256
`define DMRC_CAL_SHORT_CYC 64
// ----------------------------------------
// Controller register map
// ----------------------------------------
`define DMRC_OFF_CTRL 8'h00
`define DMRC_OFF_WORD0 8'h04
`define DMRC_OFF_WORD1 8'h08
`define DMRC_OFF_STATUS 8'h0C
`define DMRC_CTRL_SEND0 0
`define DMRC_CTRL_SEND1 1
`define DMRC_CTRL_MEMRST 2
`define DMRC_RESP_OKAY 2'h0
`define DMRC_RESP_SLVERR 2'h2
`endif

// file: verilog/dmrc_pkg.sv
// Types shared by the mode-word bank and its controller
package dmrc_pkg;
`include "dmrc_params.svh"
  typedef logic [`DMRC_WORD_W-1:0] dmrc_word_t;
  typedef logic [4:0] dmrc_lat_t;
  // Device address phase tracking
  typedef enum logic {DEV_READY, DEV_SECOND} dmrc_dev_ph_t;
  // Controller sequencing
  typedef enum logic [2:0] {C_IDLE, C_PHASE1, C_PHASE2, C_RECOV, C_WAIT} dmrc_ctl_st_t;
  // Device state
  typedef struct packed {
    dmrc_dev_ph_t ph;
    logic [1:0] sel;
    logic [`DMRC_SPLIT-1:0] low;
    dmrc_word_t word0;
    dmrc_word_t word1;
    logic dll_rst_p;
    logic bl_chg;
    logic cal_busy;
    logic cal_long;
    logic init_done;
    logic [15:0] cal_cnt;
  } dmrc_dev_state_t;
  // Controller state
  typedef struct packed {
    dmrc_ctl_st_t st;
    logic [15:0] cnt;
    dmrc_word_t w0;
    dmrc_word_t w1;
    dmrc_word_t cur;
    logic [1:0] cur_sel;
    logic pend0;
    logic pend1;
    logic auto_rst;
    logic mux_on;
    logic init_done;
    logic err;
    logic mem_rst;
    logic cs_n;
    logic we_n;
    logic ref_n;
    logic [3:0] ba;
    logic [`DMRC_ADDR_W-1:0] addr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dmrc_ctl_state_t;
endpackage

// file: verilog/dmrc_if.sv
// Command and address link between controller and DRAM mode-word bank
`timescale 1ns/1ps
interface dmrc_if;
  logic cs_n;
  logic we_n;
  logic ref_n;
  logic [3:0] ba;
  logic [20:0] addr;
  logic reset_n;
  // Controller drives the bus
  modport ctl (output cs_n, output we_n, output ref_n, output ba, output addr, output reset_n);
  // Device samples the bus
  modport dev (input cs_n, input we_n, input ref_n, input ba, input addr, input reset_n);
endinterface

// file: verilog/dmrc_device.sv
// Device end: DRAM mode-word bank and the effects of its fields
`timescale 1ns/1ps
`include "dmrc_params.svh"
// Behaviour
// - Row cycle count from word zero bits 3:0
// - Controller waits row cycle per bank; it only sends mode-set, so it has no row-cycle wait
// - Controller programs only allowed row codes
// - Bits 7:4 set read and write latency
// - Bit 8 enables DLL; keep enabled
// - DLL off: row code equals read latency; controller checks it against the latency code
// - Follow DLL enable with DLL reset
// - Multiplexed mode sends address in two parts
// - Multiplexed mode uses eleven address inputs
// - Bank bits 2,3 and reserved bits low
// - Impedance 40 or 60 ohm, reset 40
// - Bits 4:2 select termination value
// - Data termination off while driving reads
// - DLL reset bit self-clears after start
// - Wait 512 cycles before any read
// - Bit 6 picks calibration, bit 7 starts
// - Channel idle during calibration window
// - Initial versus operational long calibration window
// - Shared resistor windows never overlap
// - Bit 8 selects refresh protocol
// - Bits 10:9 set burst length, width
// - Old data unsure after burst change
// - Mode-set is all three strobes low
// - Words persist until rewrite or reset
module dmrc_device #(
  parameter bit WIDE36 = 1'b0,
  parameter int CAL_INIT_CYC = `DMRC_CAL_INIT_CYC,
  parameter int CAL_OPER_CYC = `DMRC_CAL_OPER_CYC,
  parameter int CAL_SHORT_CYC = `DMRC_CAL_SHORT_CYC
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Command and address bus
  dmrc_if.dev BUS,
  // Read data activity
  input wire logic READ_DRIVING,
  // Timing settings
  output logic [3:0] ROW_CYCLES,
  output dmrc_pkg::dmrc_lat_t READ_LATENCY,
  output dmrc_pkg::dmrc_lat_t WRITE_LATENCY,
  // DLL control
  output logic DLL_ENABLE,
  output logic DLL_RESET,
  // Addressing
  output logic MUX_ADDR,
  output logic [4:0] ADDR_INPUTS,
  output logic [4:0] ADDR_WIDTH,
  // Output driver and termination
  output logic DRIVE_60_OHM,
  output logic [2:0] ODT_CODE,
  output logic ODT_DQ_ON,
  output logic ODT_MASK_ON,
  // Calibration
  output logic CAL_BUSY,
  output logic CAL_LONG,
  // Refresh and burst
  output logic REFRESH_MULTI,
  output logic [3:0] BURST_LEN,
  output logic BL_CHANGED,
  // Stored words
  output dmrc_pkg::dmrc_word_t WORD0,
  output dmrc_pkg::dmrc_word_t WORD1
);
  import dmrc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  dmrc_dev_state_t s_r; // All registered state
  dmrc_dev_state_t s_nxt; // Next value
  logic mode_set; // Mode-set seen this edge
  logic load; // A full word is ready
  logic [1:0] sel_in; // Target word of the load
  dmrc_word_t word_in; // Assembled word
  dmrc_word_t w1; // Word one after fixups
  logic [1:0] bl_in; // Requested burst code
  logic bl_bad; // Burst code not allowed on this part
  logic cal_start; // New calibration begins

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.dll_rst_p = 1'b0;
    s_nxt.bl_chg = 1'b0;
    load = 1'b0;
    sel_in = `DMRC_SEL_WORD0;
    word_in = '0;
    w1 = '0;
    bl_in = `DMRC_BL_2;
    bl_bad = 1'b0;
    cal_start = 1'b0;
    // Mode-set decode, all strobes low on the edge
    mode_set = !BUS.cs_n && !BUS.we_n && !BUS.ref_n;
    case (s_r.ph)
      DEV_READY: begin
        if (mode_set && s_r.word0[`DMRC_MUX_BIT]) begin
          // First part: bank select and low word bits
          s_nxt.ph = DEV_SECOND;
          s_nxt.sel = BUS.ba[1:0];
          s_nxt.low = BUS.addr[`DMRC_SPLIT-1:0];
        end else if (mode_set) begin
          // Broadside: whole word on one edge
          load = 1'b1;
          sel_in = BUS.ba[1:0];
          word_in = BUS.addr[`DMRC_WORD_W-1:0];
        end
      end
      DEV_SECOND: begin
        // Second part on the next edge; only low inputs count
        load = 1'b1;
        sel_in = s_r.sel;
        word_in = {BUS.addr[`DMRC_WORD_W-`DMRC_SPLIT-1:0], s_r.low};
        s_nxt.ph = DEV_READY;
      end
      default: begin
        s_nxt.ph = DEV_READY;
      end
    endcase
    // Calibration countdown; go bit falls when done
    if (s_r.cal_busy) begin
      s_nxt.cal_cnt = s_r.cal_cnt - 16'h0001;
      if (s_r.cal_cnt == 16'h0001) begin
        s_nxt.cal_busy = 1'b0;
        s_nxt.word1[`DMRC_CAL_GO_BIT] = 1'b0;
        if (s_r.cal_long) begin
          s_nxt.init_done = 1'b1;
        end
      end
    end
    // Word zero load; reserved bit never stored
    if (load && sel_in == `DMRC_SEL_WORD0) begin
      s_nxt.word0 = word_in & ~`DMRC_RES0_MASK;
    end
    // Word one load with its side effects
    if (load && sel_in == `DMRC_SEL_WORD1) begin
      w1 = word_in;
      bl_in = word_in[`DMRC_BL_LSB+:2];
      // Illegal burst codes keep the old length rather than guess
      bl_bad = (bl_in == `DMRC_BL_8 && WIDE36) || bl_in > `DMRC_BL_8;
      if (bl_bad) begin
        w1[`DMRC_BL_LSB+:2] = s_r.word1[`DMRC_BL_LSB+:2];
      end
      // Stored data may be stale after a length change
      s_nxt.bl_chg = w1[`DMRC_BL_LSB+:2] != s_r.word1[`DMRC_BL_LSB+:2];
      // DLL reset is a one-cycle pulse, bit reads back zero
      s_nxt.dll_rst_p = word_in[`DMRC_DLLRST_BIT];
      w1[`DMRC_DLLRST_BIT] = 1'b0;
      // A running calibration is not restarted
      cal_start = word_in[`DMRC_CAL_GO_BIT] && !s_r.cal_busy;
      if (cal_start) begin
        s_nxt.cal_busy = 1'b1;
        s_nxt.cal_long = !word_in[`DMRC_CAL_SHORT_BIT];
        if (word_in[`DMRC_CAL_SHORT_BIT]) begin
          s_nxt.cal_cnt = 16'(CAL_SHORT_CYC);
        end else if (s_r.init_done) begin
          s_nxt.cal_cnt = 16'(CAL_OPER_CYC);
        end else begin
          s_nxt.cal_cnt = 16'(CAL_INIT_CYC);
        end
      end
      // Go bit mirrors the engine, so a go landing on a finish is dropped and reads back zero
      w1[`DMRC_CAL_GO_BIT] = s_nxt.cal_busy;
      s_nxt.word1 = w1;
    end
  end

  // ----------------------------------------
  // Registers; the reset pin clears the words too
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !BUS.reset_n) begin
      s_r <= '0;
      s_r.ph <= DEV_READY;
      s_r.word0 <= `DMRC_WORD0_RST;
      s_r.word1 <= `DMRC_WORD1_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign ROW_CYCLES = s_r.word0[`DMRC_RC_LSB+:4];
  // Write latency always one above read latency
  assign READ_LATENCY = `DMRC_LAT_BASE + {1'b0, s_r.word0[`DMRC_LAT_LSB+:4]};
  assign WRITE_LATENCY = READ_LATENCY + 5'h01;
  assign DLL_ENABLE = s_r.word0[`DMRC_DLL_EN_BIT];
  assign DLL_RESET = s_r.dll_rst_p;
  assign MUX_ADDR = s_r.word0[`DMRC_MUX_BIT];
  assign ADDR_INPUTS = MUX_ADDR ? `DMRC_ADDR_IN_MUX : `DMRC_ADDR_IN_FULL;
  // Width shrinks one bit per doubling of burst
  assign ADDR_WIDTH = (WIDE36 ? 5'h14 : 5'h15) - {3'h0, s_r.word1[`DMRC_BL_LSB+:2]};
  assign DRIVE_60_OHM = s_r.word1[`DMRC_DRV_LSB+:2] == `DMRC_DRV_60;
  assign ODT_CODE = s_r.word1[`DMRC_ODT_LSB+:3];
  // Mask stays terminated; data lines drop while driving
  assign ODT_MASK_ON = ODT_CODE != `DMRC_ODT_OFF;
  assign ODT_DQ_ON = ODT_MASK_ON && !READ_DRIVING;
  assign CAL_BUSY = s_r.cal_busy;
  assign CAL_LONG = s_r.cal_long;
  assign REFRESH_MULTI = s_r.word1[`DMRC_REF_MULTI_BIT];
  assign BURST_LEN = 4'h2 << s_r.word1[`DMRC_BL_LSB+:2];
  assign BL_CHANGED = s_r.bl_chg;
  assign WORD0 = s_r.word0;
  assign WORD1 = s_r.word1;
endmodule

// file: verilog/dmrc_controller.sv
// Controller end: AXI4-Lite registers that issue mode-set commands
`timescale 1ns/1ps
`include "dmrc_params.svh"
module dmrc_controller #(
  parameter int MRSC_CYC = `DMRC_MRSC_CYC,
  parameter int DLL_LOCK_CYC = `DMRC_DLL_LOCK_CYC,
  parameter int CAL_INIT_CYC = `DMRC_CAL_INIT_CYC,
  parameter int CAL_OPER_CYC = `DMRC_CAL_OPER_CYC,
  parameter int CAL_SHORT_CYC = `DMRC_CAL_SHORT_CYC
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // AXI4-Lite write channels
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Memory command bus
  dmrc_if.ctl BUS
);
  import dmrc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  dmrc_ctl_state_t s_r; // All registered state
  dmrc_ctl_state_t s_nxt; // Next value
  logic wr_go; // Write address and data taken together
  logic rd_go; // Read address taken
  dmrc_word_t wv; // Written word, low bits
  dmrc_word_t pick; // Word about to be sent
  logic bad0; // Word zero breaks programming limits

  assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !s_r.bvalid;
  assign rd_go = S_AXI_ARVALID && !s_r.rvalid;
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign S_AXI_ARREADY = rd_go;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    wv = S_AXI_WDATA[`DMRC_WORD_W-1:0];
    pick = '0;
    bad0 = 1'b0;
    // Idle bus is a NOP; bank bits 3:2 always low
    s_nxt.cs_n = 1'b1;
    s_nxt.we_n = 1'b1;
    s_nxt.ref_n = 1'b1;
    s_nxt.ba = 4'h0;
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    // Sequencer
    case (s_r.st)
      C_IDLE: begin
        if (s_r.pend0 || s_r.pend1) begin
          s_nxt.cur_sel = s_r.pend0 ? `DMRC_SEL_WORD0 : `DMRC_SEL_WORD1;
          pick = s_r.pend0 ? (s_r.w0 & ~`DMRC_RES0_MASK) : s_r.w1;
          if (!s_r.pend0 && s_r.auto_rst) begin
            pick[`DMRC_DLLRST_BIT] = 1'b1;
          end
          // Row code range, and equal to latency code with DLL off
          bad0 = s_r.pend0 && (pick[3:0] < `DMRC_RC_MIN || pick[3:0] > `DMRC_RC_MAX
            || (!pick[`DMRC_DLL_EN_BIT] && pick[3:0] != pick[7:4]));
          if (s_r.pend0) begin
            s_nxt.pend0 = 1'b0;
          end else begin
            s_nxt.pend1 = 1'b0;
            s_nxt.auto_rst = 1'b0;
          end
          s_nxt.err = bad0;
          s_nxt.cur = pick;
          s_nxt.st = bad0 ? C_IDLE : C_PHASE1;
        end
      end
      C_PHASE1: begin
        // Mode-set with full word, or first part when multiplexed
        // Only mode-set ever goes out, so no bank command needs row spacing
        s_nxt.cs_n = 1'b0;
        s_nxt.we_n = 1'b0;
        s_nxt.ref_n = 1'b0;
        s_nxt.ba = {2'h0, s_r.cur_sel};
        s_nxt.addr = s_r.mux_on ? {15'h0, s_r.cur[`DMRC_SPLIT-1:0]} : {10'h000, s_r.cur};
        s_nxt.st = s_r.mux_on ? C_PHASE2 : C_RECOV;
        s_nxt.cnt = 16'(MRSC_CYC);
        if (s_r.cur_sel == `DMRC_SEL_WORD0) begin
          // The new addressing applies from the next command
          s_nxt.mux_on = s_r.cur[`DMRC_MUX_BIT];
        end
      end
      C_PHASE2: begin
        // Second part on the following edge
        s_nxt.addr = {16'h0000, s_r.cur[`DMRC_WORD_W-1:`DMRC_SPLIT]};
        s_nxt.st = C_RECOV;
      end
      C_RECOV: begin
        // Recovery before the next command
        s_nxt.addr = '0;
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt <= 16'h0001) begin
          s_nxt.st = C_IDLE;
          if (s_r.cur_sel == `DMRC_SEL_WORD0 && s_r.cur[`DMRC_DLL_EN_BIT]) begin
            s_nxt.pend1 = 1'b1;
            s_nxt.auto_rst = 1'b1;
          end else if (s_r.cur_sel == `DMRC_SEL_WORD1) begin
            // Hold the channel quiet for lock or calibration
            if (s_r.cur[`DMRC_CAL_GO_BIT]) begin
              s_nxt.st = C_WAIT;
              if (s_r.cur[`DMRC_CAL_SHORT_BIT]) begin
                s_nxt.cnt = 16'(CAL_SHORT_CYC);
              end else if (s_r.init_done) begin
                s_nxt.cnt = 16'(CAL_OPER_CYC);
              end else begin
                s_nxt.cnt = 16'(CAL_INIT_CYC);
                s_nxt.init_done = 1'b1;
              end
            end
            if (s_r.cur[`DMRC_DLLRST_BIT]) begin
              s_nxt.st = C_WAIT;
              if (!s_r.cur[`DMRC_CAL_GO_BIT] || 16'(DLL_LOCK_CYC) > s_nxt.cnt) begin
                s_nxt.cnt = 16'(DLL_LOCK_CYC);
              end
            end
          end
        end
      end
      C_WAIT: begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt <= 16'h0001) begin
          s_nxt.st = C_IDLE;
        end
      end
      default: begin
        s_nxt.st = C_IDLE;
      end
    endcase
    // Register writes; a send request wins over the sequencer's clear
    if (wr_go) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `DMRC_RESP_OKAY;
      case (S_AXI_AWADDR)
        `DMRC_OFF_CTRL: begin
          if (S_AXI_WSTRB[0]) begin
            s_nxt.pend0 = s_nxt.pend0 | S_AXI_WDATA[`DMRC_CTRL_SEND0];
            s_nxt.pend1 = s_nxt.pend1 | S_AXI_WDATA[`DMRC_CTRL_SEND1];
            s_nxt.mem_rst = S_AXI_WDATA[`DMRC_CTRL_MEMRST];
          end
        end
        `DMRC_OFF_WORD0: begin
          if (S_AXI_WSTRB[0]) s_nxt.w0[7:0] = wv[7:0];
          if (S_AXI_WSTRB[1]) s_nxt.w0[10:8] = wv[10:8];
        end
        `DMRC_OFF_WORD1: begin
          if (S_AXI_WSTRB[0]) s_nxt.w1[7:0] = wv[7:0];
          if (S_AXI_WSTRB[1]) s_nxt.w1[10:8] = wv[10:8];
        end
        `DMRC_OFF_STATUS: begin
          s_nxt.bresp = `DMRC_RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = `DMRC_RESP_SLVERR;
        end
      endcase
    end
    // A memory reset returns the link to broadside addressing
    if (s_nxt.mem_rst) begin
      s_nxt.mux_on = 1'b0;
      s_nxt.init_done = 1'b0;
    end
    // Register reads
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `DMRC_RESP_OKAY;
      case (S_AXI_ARADDR)
        `DMRC_OFF_CTRL: s_nxt.rdata = {29'h0, s_r.mem_rst, s_r.pend1, s_r.pend0};
        `DMRC_OFF_WORD0: s_nxt.rdata = {21'h0, s_r.w0};
        `DMRC_OFF_WORD1: s_nxt.rdata = {21'h0, s_r.w1};
        // Busy covers queued words, so a poll never slips into the idle gap
        `DMRC_OFF_STATUS: s_nxt.rdata = {27'h0, s_r.mux_on, s_r.init_done,
          s_r.st == C_WAIT, s_r.err, s_r.st != C_IDLE || s_r.pend0 || s_r.pend1};
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = `DMRC_RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      s_r <= '0;
      s_r.st <= C_IDLE;
      s_r.cs_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.ref_n <= 1'b1;
      s_r.w0 <= `DMRC_WORD0_RST;
      s_r.w1 <= `DMRC_WORD1_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign BUS.cs_n = s_r.cs_n;
  assign BUS.we_n = s_r.we_n;
  assign BUS.ref_n = s_r.ref_n;
  assign BUS.ba = s_r.ba;
  assign BUS.addr = s_r.addr;
  assign BUS.reset_n = !s_r.mem_rst;
  assign S_AXI_BVALID = s_r.bvalid;
  assign S_AXI_BRESP = s_r.bresp;
  assign S_AXI_RVALID = s_r.rvalid;
  assign S_AXI_RRESP = s_r.rresp;
  assign S_AXI_RDATA = s_r.rdata;
endmodule

// file: tb/dmrc_link_asserts.sv
// Checker for the mode-set link between controller and device
`timescale 1ns/1ps
module dmrc_link_asserts (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Link signals
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic [3:0] ba,
  input wire logic [20:0] addr,
  input wire logic reset_n
);
  // ----------------------------------------
  // Multiplexed mode tracking
  // ----------------------------------------
  logic mux_r; // Addressing split in force
  logic w0_r; // Word zero first part just seen
  // Follows bit 9 of each stored word zero, the split form too
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !reset_n) begin
      mux_r <= 1'b0;
      w0_r <= 1'b0;
    end else begin
      w0_r <= !cs_n && ba[1:0] == 2'h0 && mux_r;
      if (!cs_n && ba[1:0] == 2'h0 && !mux_r) begin
        mux_r <= addr[9];
      end else if (w0_r) begin
        mux_r <= addr[3];
      end
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_resv_low; !cs_n |-> ba[3:2] == 2'h0 && addr[20:11] == 10'h000; endproperty
  a_resv_low: assert property (p_resv_low) else $error("reserved lines high");
  property p_strobes; !cs_n |-> !we_n && !ref_n; endproperty
  a_strobes: assert property (p_strobes) else $error("strobes not together");
  property p_we_alone; !we_n |-> !cs_n; endproperty
  a_we_alone: assert property (p_we_alone) else $error("stray write strobe");
  property p_sel; !cs_n |-> ba[1] == 1'b0; endproperty
  a_sel: assert property (p_sel) else $error("bad word select");
  property p_recov; !cs_n |=> cs_n [*2]; endproperty
  a_recov: assert property (p_recov) else $error("command too soon");
  property p_idle; $past(SYS_RST) |-> cs_n && we_n && ref_n && reset_n; endproperty
  a_idle: assert property (p_idle) else $error("bus not idle after reset");
  property p_split;
    !cs_n && mux_r |-> addr[20:6] == 15'h0000 ##1 (cs_n && addr[20:5] == 16'h0000);
  endproperty
  a_split: assert property (p_split) else $error("bad split address");
  property p_dll_follow;
    !cs_n && ba[1:0] == 2'h0 && !mux_r && addr[8] |->
      ##[3:40] (!cs_n && ba[1:0] == 2'h1 && addr[5]);
  endproperty
  a_dll_follow: assert property (p_dll_follow) else $error("no DLL reset after enable");
endmodule

// file: tb/dram_mode_register_config_tb.sv
// Bench for the controller and device joined over the link
`timescale 1ns/1ps
module dram_mode_register_config_tb;
  import dmrc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0, rst = 1'b1, rd_drv = 1'b0, blc_seen = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dll_en, dll_rst, mux, d60, odq, omk;
  logic cbusy, clong, refm, dll_seen, cal_seen, blc;
  logic [1:0] bresp, rresp;
  logic [3:0] row, bl;
  logic [4:0] ain, aw;
  logic [2:0] odt;
  dmrc_lat_t rl, wl;
  dmrc_word_t w0, w1;
  int num_errors = 0, n_tests = 0, cyc = 0;
  dmrc_if link ();
  always #2 clk = ~clk;
  dmrc_controller #(.MRSC_CYC(2), .DLL_LOCK_CYC(8)) dmrc_controller_inst (.CLOCK(clk),
    .SYS_RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .BUS(link.ctl));
  dmrc_device dmrc_device_inst (
    .CLOCK(clk), .SYS_RST(rst), .BUS(link.dev), .READ_DRIVING(rd_drv), .ROW_CYCLES(row),
    .READ_LATENCY(rl), .WRITE_LATENCY(wl), .DLL_ENABLE(dll_en), .DLL_RESET(dll_rst),
    .MUX_ADDR(mux), .ADDR_INPUTS(ain), .ADDR_WIDTH(aw), .DRIVE_60_OHM(d60), .ODT_CODE(odt),
    .ODT_DQ_ON(odq), .ODT_MASK_ON(omk), .CAL_BUSY(cbusy), .CAL_LONG(clong),
    .REFRESH_MULTI(refm), .BURST_LEN(bl), .BL_CHANGED(blc), .WORD0(w0), .WORD1(w1));
  dmrc_link_asserts dmrc_link_asserts_inst (.CLOCK(clk), .SYS_RST(rst), .cs_n(link.cs_n),
    .we_n(link.we_n), .ref_n(link.ref_n), .ba(link.ba), .addr(link.addr),
    .reset_n(link.reset_n));
  // Pulse catchers and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dll_rst === 1'b1) dll_seen <= 1'b1;
    if (cbusy === 1'b1) cal_seen <= 1'b1;
    if (blc === 1'b1) blc_seen <= 1'b1;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Ready is sampled at the falling edge, so the next rising edge is the taking one
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic da, dw, ta, tw, got;
    logic [1:0] r;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = !da && awready === 1'b1;
      tw = !dw && wready === 1'b1;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    do begin
      @(negedge clk);
      got = bvalid === 1'b1;
      r = bresp;
      @(posedge clk);
    end while (!got);
    bready <= 1'b0;
    chk(r, er);
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic got;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      got = arready === 1'b1;
      @(posedge clk);
    end while (!got);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      got = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (!got);
    rready <= 1'b0;
    chk(r, er);
  endtask
  // Loads a shadow word, orders it sent, waits until the controller is quiet
  task send(input logic [7:0] off, input logic [31:0] w, input logic [31:0] go);
    logic [31:0] s;
    axi_wr(off, w, 2'h0);
    axi_wr(8'h00, go, 2'h0);
    s = 32'h1;
    while (s[0] !== 1'b0) axi_rd(8'h0C, s, 2'h0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_unmapped;
    logic [31:0] d;
    axi_wr(8'h10, 32'h7FF, 2'h2);
    axi_rd(8'h10, d, 2'h2);
    chk(d, 32'h0);
    chk(w0, 32'h0);
  endtask
  task t_word1;
    send(8'h08, 32'h30D, 32'h2);
    chk(w1, 32'h30D);
    chk(d60, 1);
    chk(odt, 3);
    chk(omk, 1);
    chk(refm, 1);
    chk(bl, 4);
    chk(aw, 20);
    chk(blc_seen, 1);
    rd_drv <= 1'b1;
    @(negedge clk);
    chk(odq, 0);
    @(posedge clk);
    rd_drv <= 1'b0;
    @(negedge clk);
    chk(odq, 1);
  endtask
  // Row code must match latency with the DLL off, and stay in range
  task t_rows;
    logic [31:0] s;
    send(8'h04, 32'h034, 32'h1);
    axi_rd(8'h0C, s, 2'h0);
    chk(s[1], 1);
    chk(w0, 0);
    send(8'h04, 32'h033, 32'h1);
    chk(row, 3);
    chk(rl, 8);
    chk(wl, 9);
    chk(dll_en, 0);
    send(8'h04, 32'h10A, 32'h1);
    chk(w0, 32'h033);
  endtask
  task t_dll_mux;
    dll_seen = 1'b0;
    send(8'h04, 32'h303, 32'h1);
    chk(dll_en, 1);
    chk(mux, 1);
    chk(ain, 11);
    chk(dll_seen, 1);
    chk(w1, 32'h30D);
  endtask
  // Long then short calibration, sent over the split address
  task t_calib;
    cal_seen = 1'b0;
    send(8'h08, 32'h38D, 32'h2);
    while (cbusy === 1'b1) @(posedge clk);
    chk(cal_seen, 1);
    chk(clong, 1);
    chk(w1, 32'h30D);
    send(8'h08, 32'h3CD, 32'h2);
    while (cbusy === 1'b1) @(posedge clk);
    chk(clong, 0);
    chk(w1, 32'h34D);
  endtask
  // Memory reset pin clears both words and the split addressing
  task t_memrst;
    axi_wr(8'h00, 32'h4, 2'h0);
    @(posedge clk);
    chk(w1, 32'h0);
    chk(mux, 0);
    axi_wr(8'h00, 32'h0, 2'h0);
    chk(link.reset_n, 1);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(w0, 0);
    chk(d60, 0);
    chk(bl, 2);
    chk(rl, 5);
    t_unmapped();
    t_word1();
    t_rows();
    t_dll_mux();
    t_calib();
    t_memrst();
    tally_and_finish();
  end
endmodule
